// file: rtl/opdc_regs.svh
/*
 * register offsets, field positions and reset values of the output pll divider control block.
 * assumes byte addresses on a 32-bit ahb-lite bus; included by bare name.
 */
`ifndef OPDC_REGS_SVH
`define OPDC_REGS_SVH

// ****************************************
// register offsets (word index and byte address)
// ****************************************
`define OPDC_IDX_LF_BYPASS   12'h404
`define OPDC_IDX_SYNC_CAL    12'h405
`define OPDC_IDX_SPARE       12'h406
`define OPDC_IDX_RF_RATIO    12'h407
`define OPDC_IDX_RF_POWER    12'h408
`define OPDC_ADDR_LF_BYPASS  14'h1010
`define OPDC_ADDR_SYNC_CAL   14'h1014
`define OPDC_ADDR_SPARE      14'h1018
`define OPDC_ADDR_RF_RATIO   14'h101c
`define OPDC_ADDR_RF_POWER   14'h1020

// ****************************************
// field positions
// ****************************************
`define OPDC_BIT_RZERO_BYP   0
`define OPDC_BIT_SYNC_OVR    3
`define OPDC_BIT_VCO_CAL     0
`define OPDC_BIT_STARTUP     4
`define OPDC_BIT_PD_RF2      1
`define OPDC_BIT_PD_RF1      0

// ****************************************
// reset values
// ****************************************
`define OPDC_RST_LF_BYPASS   8'h00
`define OPDC_RST_SYNC_CAL    8'h20
`define OPDC_RST_SPARE       8'h00
`define OPDC_RST_RF_RATIO    8'h44
`define OPDC_RST_RF_POWER    8'h02
`define OPDC_RST_AUTOSYNC    2'h2

// ****************************************
// divider coding
// ****************************************
`define OPDC_RATIO_MIN       4'h3
`define OPDC_RATIO_MAX       4'hb
`define OPDC_CODE_MAX        4'h9

`endif

// file: rtl/opdc_pkg.sv
/*
 * types shared by the output pll divider control block.
 * assumes nothing of its surroundings.
 */
package opdc_pkg;
    // ****************************************
    // rf divider control, one per divider
    // ****************************************
    typedef struct packed {
        logic       run;     // divider released from power-down
        logic [3:0] ratio;   // division ratio 3..11
    } opdc_rfdiv_t;

    // startup hold-off states
    typedef enum logic [1:0] {
        OPDC_HOLD = 2'b01,   // waiting for feedback divider activity
        OPDC_FREE = 2'b10    // feedback divider seen; the startup bit skip leaves this state alone
    } opdc_startup_t;
endpackage

// file: rtl/opdc_rfdiv_ctl.sv
/*
 * one rf divider's control decoder: code to ratio and run gating.
 * assumes the caller supplies registered code, power-down and release.
 */
`timescale 1ns/1ps
`include "opdc_regs.svh"

module opdc_rfdiv_ctl (
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    input  wire logic [3:0]           code,
    input  wire logic                 pd,
    input  wire logic                 release_ok,
    output opdc_pkg::opdc_rfdiv_t     ctl
);
    // ****************************************
    // code decode
    // ****************************************
    // map a 4-bit code to its ratio
    function automatic logic [3:0] decode_ratio(input logic [3:0] c);
        if (c <= 4'h1) begin
            decode_ratio = `OPDC_RATIO_MIN;
        end else if (c > `OPDC_CODE_MAX) begin
            decode_ratio = `OPDC_RATIO_MAX;
        end else begin
            decode_ratio = c + 4'h2;
        end
    endfunction

    // registered control out; divider runs only when enabled and released
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // ratio parks at a legal value so the range check holds out of reset
            ctl.run   <= 1'b0;
            ctl.ratio <= `OPDC_RATIO_MIN;
        end else if (clk_en) begin
            ctl.ratio <= decode_ratio(code);
            ctl.run   <= !pd && release_ok;
        end
    end

    a_ratio_range: assert property (@(posedge clock) disable iff (!rst_n)
        ctl.ratio >= `OPDC_RATIO_MIN && ctl.ratio <= `OPDC_RATIO_MAX)
        else $error("rf divider ratio out of range");
endmodule // opdc_rfdiv_ctl

// file: rtl/opdc_top.sv
/*
 * output pll divider control: ahb-lite register slave, sync gating,
 * manual vco calibration trigger and rf divider control.
 * assumes one 50 mhz clock, synchronous status inputs from the analog pll,
 * a single ahb-lite master with word transfers.
 *
// Summary of operation
// - bit zero bypasses the internal zero resistor
// - sync held until apll calibrated and locked
// - override bit lets sync ignore apll lock
// - calibration starts only on rising bit edge
// - calibration bit never self-clears; software rewrites
// - divider two code maps to ratio three-eleven
// - divider one code uses same mapping
// - dividers held down until feedback divider seen
// - startup bit set skips feedback hold-off
// - divider two power-down bit, resets high
// - divider one power-down bit, resets low
// - armed autosync defaults to dpll phase lock
 */
`timescale 1ns/1ps
`include "opdc_regs.svh"

module opdc_top (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    // ahb-lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // analog pll status
    input  wire logic                 apll_cal_done,
    input  wire logic                 apll_locked,
    input  wire logic                 fb_div_active,
    // controls out
    output logic                      rzero_bypass,
    output logic                      vco_cal_start,
    output logic                      sync_armed,
    output logic [1:0]                autosync_mode,
    output opdc_pkg::opdc_rfdiv_t     rf1_ctl,
    output opdc_pkg::opdc_rfdiv_t     rf2_ctl
);
    // ****************************************
    // reset release
    // ****************************************
    logic       rst_meta_reg;    // first stage, read only by second
    logic       rst_n_reg;       // synchronised reset used everywhere

    // release reset through two flops
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] lf_reg;          // loop filter zero bypass
    logic [7:0] sync_cal_reg;    // sync gate and calibration
    logic [7:0] ratio_reg;       // rf divider ratios
    logic [7:0] power_reg;       // rf power and startup mode
    opdc_pkg::opdc_startup_t startup_state; // feedback divider hold-off
    logic                    release_ok;    // rf dividers may leave power-down

    // ****************************************
    // ahb-lite address phase capture
    // ****************************************
    logic        wr_pend_reg;    // write data phase pending
    logic [13:0] wr_addr_reg;    // captured byte address
    logic        rd_pend_reg;    // read data phase pending
    logic        take;           // valid transfer accepted this cycle

    // nonseq or seq while selected and bus ready
    assign take = hsel && hready && htrans[1];

    // capture address phase for the data phase that follows
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else if (clk_en) begin
            if (hready) begin
                wr_pend_reg <= take && hwrite;
                rd_pend_reg <= take && !hwrite;
                wr_addr_reg <= haddr[13:0];
            end
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ****************************************
    // register writes
    // ****************************************
    // each register updated on its own decoded address; reserved bits forced
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            lf_reg       <= `OPDC_RST_LF_BYPASS;
            sync_cal_reg <= `OPDC_RST_SYNC_CAL;
            ratio_reg    <= `OPDC_RST_RF_RATIO;
            power_reg    <= `OPDC_RST_RF_POWER;
        end else if (clk_en && wr_pend_reg) begin
            if (wr_addr_reg == `OPDC_ADDR_LF_BYPASS) begin
                lf_reg <= {7'h00, hwdata[0]};
            end else if (wr_addr_reg == `OPDC_ADDR_SYNC_CAL) begin
                // calibration bit stays as written: no self-clear
                sync_cal_reg <= {4'h2, hwdata[3], 2'h0, hwdata[0]};
            end else if (wr_addr_reg == `OPDC_ADDR_RF_RATIO) begin
                ratio_reg <= hwdata[7:0];
            end else if (wr_addr_reg == `OPDC_ADDR_RF_POWER) begin
                power_reg <= {3'h0, hwdata[4], 2'h0, hwdata[1:0]};
            end
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // registered read data; unmapped and spare addresses read zero
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hrdata <= '0;
        end else if (clk_en) begin
            if (take && !hwrite) begin
                if (haddr[13:0] == `OPDC_ADDR_LF_BYPASS) begin
                    hrdata <= {24'h000000, lf_reg};
                end else if (haddr[13:0] == `OPDC_ADDR_SYNC_CAL) begin
                    hrdata <= {24'h000000, sync_cal_reg};
                end else if (haddr[13:0] == `OPDC_ADDR_RF_RATIO) begin
                    hrdata <= {24'h000000, ratio_reg};
                end else if (haddr[13:0] == `OPDC_ADDR_RF_POWER) begin
                    hrdata <= {23'h000000, startup_state == opdc_pkg::OPDC_FREE,
                               power_reg};
                end else begin
                    hrdata <= '0;  // spare and unmapped
                end
            end
        end
    end

    // ****************************************
    // loop filter
    // ****************************************
    assign rzero_bypass = lf_reg[`OPDC_BIT_RZERO_BYP];

    // ****************************************
    // vco calibration trigger
    // ****************************************
    logic cal_prev_reg;   // last seen calibration bit

    // one-cycle start only on a 0 to 1 change of the stored bit
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cal_prev_reg  <= 1'b0;
            vco_cal_start <= 1'b0;
        end else if (clk_en) begin
            cal_prev_reg  <= sync_cal_reg[`OPDC_BIT_VCO_CAL];
            vco_cal_start <= sync_cal_reg[`OPDC_BIT_VCO_CAL] && !cal_prev_reg;
        end
    end

    // ****************************************
    // distribution sync gate
    // ****************************************
    // armed once the apll is calibrated and locked, or always under override
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sync_armed    <= 1'b0;
            autosync_mode <= `OPDC_RST_AUTOSYNC;
        end else if (clk_en) begin
            if (sync_cal_reg[`OPDC_BIT_SYNC_OVR]) begin
                sync_armed <= 1'b1;
            end else begin
                sync_armed <= apll_cal_done && apll_locked;
            end
            autosync_mode <= `OPDC_RST_AUTOSYNC;
        end
    end

    // ****************************************
    // rf divider startup hold-off
    // ****************************************

    // leave hold once feedback divider activity seen; full reset re-arms
    always_ff @(posedge clock or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            startup_state <= opdc_pkg::OPDC_HOLD;
        end else if (clk_en) begin
            case (startup_state)
                opdc_pkg::OPDC_HOLD: begin
                    if (fb_div_active) begin
                        startup_state <= opdc_pkg::OPDC_FREE;
                    end
                end
                opdc_pkg::OPDC_FREE: begin
                    startup_state <= opdc_pkg::OPDC_FREE;
                end
                default: begin
                    startup_state <= opdc_pkg::OPDC_HOLD;
                end
            endcase
        end
    end

    // startup bit skips the wait
    assign release_ok = power_reg[`OPDC_BIT_STARTUP]
                        || startup_state == opdc_pkg::OPDC_FREE;

    // ****************************************
    // rf dividers
    // ****************************************
    opdc_rfdiv_ctl u_rf1 (
        .clock      (clock),
        .rst_n      (rst_n_reg),
        .clk_en     (clk_en),
        .code       (ratio_reg[3:0]),
        .pd         (power_reg[`OPDC_BIT_PD_RF1]),
        .release_ok (release_ok),
        .ctl        (rf1_ctl)
    );

    opdc_rfdiv_ctl u_rf2 (
        .clock      (clock),
        .rst_n      (rst_n_reg),
        .clk_en     (clk_en),
        .code       (ratio_reg[7:4]),
        .pd         (power_reg[`OPDC_BIT_PD_RF2]),
        .release_ok (release_ok),
        .ctl        (rf2_ctl)
    );

    // ****************************************
    // assertions
    // ****************************************
    sequence s_cal_rise;
        clk_en && sync_cal_reg[`OPDC_BIT_VCO_CAL] && !cal_prev_reg;
    endsequence

    a_cal_edge_only: assert property (@(posedge clock) disable iff (!rst_n_reg)
        vco_cal_start |-> $past(sync_cal_reg[`OPDC_BIT_VCO_CAL]) && !$past(cal_prev_reg))
        else $error("calibration start without rising edge");

    a_cal_pulse: assert property (@(posedge clock) disable iff (!rst_n_reg)
        s_cal_rise |=> vco_cal_start)
        else $error("rising edge missed calibration start");

    a_cal_sticky: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (sync_cal_reg[0] && !(clk_en && wr_pend_reg)) |=> sync_cal_reg[0])
        else $error("calibration bit cleared by hardware");

    a_sync_gate: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && !sync_cal_reg[3] && !(apll_cal_done && apll_locked)) |=> !sync_armed)
        else $error("sync armed before apll locked");

    a_sync_override: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && sync_cal_reg[3]) |=> sync_armed)
        else $error("override did not arm sync");

    a_rf_hold: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && !release_ok) |=> !rf1_ctl.run && !rf2_ctl.run)
        else $error("rf divider ran during hold-off");

    // run is registered from the same-cycle release, so it follows one edge later
    a_rf_skip: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && power_reg[4] && !power_reg[0]) |=> rf1_ctl.run)
        else $error("startup skip did not release divider");

    a_rf2_down: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && power_reg[1]) |=> !rf2_ctl.run)
        else $error("divider two ran while powered down");

    a_rf1_down: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && power_reg[0]) |=> !rf1_ctl.run)
        else $error("divider one ran while powered down");

    a_rzero_out: assert property (@(posedge clock) disable iff (!rst_n_reg)
        rzero_bypass == lf_reg[0] && lf_reg[7:1] == 7'h00)
        else $error("zero resistor bypass mismatch");

    a_autosync_dflt: assert property (@(posedge clock) disable iff (!rst_n_reg)
        autosync_mode == 2'h2)
        else $error("autosync not phase lock");

    a_ratio_decode: assert property (@(posedge clock) disable iff (!rst_n_reg)
        (clk_en && ratio_reg[3:0] == 4'h4) |=> rf1_ctl.ratio == 4'h6)
        else $error("divider one code four not ratio six");
endmodule // opdc_top

// file: test/output_pll_divider_control_bench.sv
/*
 * self-checking bench for the output pll divider control block.
 * assumes opdc_top with an ahb-lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
`include "opdc_regs.svh"

module output_pll_divider_control_bench;
    // ****************************************
    // signals
    // ****************************************
    logic                  clock;           // 50 mhz bench clock
    logic                  reset_n;         // active-low reset
    logic                  clk_en;          // clock enable, low freezes the block
    logic                  hsel;            // slave select
    logic [31:0]           haddr;           // byte address
    logic [1:0]            htrans;          // transfer kind
    logic                  hwrite;          // write strobe
    logic [31:0]           hwdata;          // write data
    logic [31:0]           hrdata;          // read data
    logic                  hreadyout;       // slave ready, also bus hready
    logic                  hresp;           // response code
    logic                  apll_cal_done;   // pll calibrated
    logic                  apll_locked;     // pll locked
    logic                  fb_div_active;   // feedback divider seen
    logic                  rzero_bypass;    // zero resistor bypass
    logic                  vco_cal_start;   // calibration pulse
    logic                  sync_armed;      // sync armed
    logic [1:0]            autosync_mode;   // autosync mode
    opdc_pkg::opdc_rfdiv_t rf1_ctl;         // divider 1 control
    opdc_pkg::opdc_rfdiv_t rf2_ctl;         // divider 2 control
    int                    num_errors;      // mismatches
    int                    tests_run;       // comparisons
    int                    cal_cnt;         // calibration pulses seen
    int                    seed;            // random seed
    logic [31:0]           rd;              // last read word
    logic [31:0]           r;               // random draw

    // hsize is tied: the bus only carries whole words
    opdc_top u_dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .apll_cal_done(apll_cal_done), .apll_locked(apll_locked),
        .fb_div_active(fb_div_active), .rzero_bypass(rzero_bypass),
        .vco_cal_start(vco_cal_start), .sync_armed(sync_armed),
        .autosync_mode(autosync_mode), .rf1_ctl(rf1_ctl), .rf2_ctl(rf2_ctl));

    // clock generator
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // count calibration pulses; a level would count many times
    always @(posedge clock) begin
        if (vco_cal_start === 1'b1) begin
            cal_cnt++;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    // ratio expected from a 4-bit code
    function automatic logic [3:0] exp_ratio(input logic [3:0] c);
        if (c <= 4'h1) return 4'h3;
        if (c > 4'h9) return 4'hb;
        return c + 4'h2;
    endfunction

    // compare and report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // wait for hready under a bound
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            $display("[ERR] hready expected 1 seen %b", hreadyout);
            num_errors++;
            end_sim();
        end
    endtask

    // one single-word transfer, write or read
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(name, e, rd);
    endtask

    task automatic settle();
        repeat (3) @(posedge clock);
    endtask

    // closing report
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        end_sim();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        seed = 71;
        num_errors = 0;
        tests_run = 0;
        cal_cnt = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        apll_cal_done = 1'b0;
        apll_locked = 1'b0;
        fb_div_active = 1'b0;
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        // reset values and unmapped space
        rd_chk("lf reg", `OPDC_ADDR_LF_BYPASS, 32'h00);
        rd_chk("sync reg", `OPDC_ADDR_SYNC_CAL, 32'h20);
        rd_chk("spare reg", `OPDC_ADDR_SPARE, 32'h00);
        rd_chk("ratio reg", `OPDC_ADDR_RF_RATIO, 32'h44);
        rd_chk("unmapped", 32'h1030, 32'h00);
        bus(1'b0, `OPDC_ADDR_RF_POWER, 32'h0);
        chk("power reg", 32'h02, rd & 32'hff);
        chk("autosync", 32'h2, autosync_mode);
        chk("rf1 ratio", 32'h6, rf1_ctl.ratio);
        chk("rf1 held", 32'h0, rf1_ctl.run);
        chk("rf2 run", 32'h0, rf2_ctl.run);
        chk("armed", 32'h0, sync_armed);
        $display("test reset done");
        // loop filter bypass, reserved bits read reset value
        wr(`OPDC_ADDR_LF_BYPASS, 8'h01);
        settle();
        chk("rzero", 32'h1, rzero_bypass);
        wr(`OPDC_ADDR_LF_BYPASS, 8'hfe);
        wr(`OPDC_ADDR_SPARE, 8'hff);
        settle();
        chk("rzero", 32'h0, rzero_bypass);
        rd_chk("lf reg", `OPDC_ADDR_LF_BYPASS, 32'h00);
        rd_chk("spare reg", `OPDC_ADDR_SPARE, 32'h00);
        $display("test bypass done");
        // random lock states with and without override
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            @(posedge clock);
            apll_cal_done <= r[0];
            apll_locked   <= r[1];
            wr(`OPDC_ADDR_SYNC_CAL, {4'h0, r[2], 3'h0});
            settle();
            chk("armed", {31'h0, r[2] | (r[0] & r[1])}, sync_armed);
        end
        $display("test sync done");
        // calibration trigger on rising bit only
        wr(`OPDC_ADDR_SYNC_CAL, 8'h00);
        settle();
        r = cal_cnt;
        wr(`OPDC_ADDR_SYNC_CAL, 8'h01);
        settle();
        chk("cal pulses", r + 1, cal_cnt);
        wr(`OPDC_ADDR_SYNC_CAL, 8'hf7);
        settle();
        chk("cal pulses", r + 1, cal_cnt);
        rd_chk("sync reg", `OPDC_ADDR_SYNC_CAL, 32'h21);
        wr(`OPDC_ADDR_SYNC_CAL, 8'h00);
        wr(`OPDC_ADDR_SYNC_CAL, 8'h01);
        settle();
        chk("cal pulses", r + 2, cal_cnt);
        $display("test calibration done");
        // every code on divider 1, random codes on divider 2
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            wr(`OPDC_ADDR_RF_RATIO, {r[3:0], i[3:0]});
            settle();
            chk("rf1 ratio", exp_ratio(i[3:0]), rf1_ctl.ratio);
            chk("rf2 ratio", exp_ratio(r[3:0]), rf2_ctl.ratio);
        end
        rd_chk("ratio reg", `OPDC_ADDR_RF_RATIO, {24'h0, r[3:0], 4'hf});
        $display("test ratios done");
        // power-down bits and start-up hold-off
        wr(`OPDC_ADDR_RF_POWER, 8'h00);
        settle();
        chk("rf1 held", 32'h0, rf1_ctl.run);
        chk("rf2 held", 32'h0, rf2_ctl.run);
        wr(`OPDC_ADDR_RF_POWER, 8'h10);
        settle();
        chk("rf1 free", 32'h1, rf1_ctl.run);
        chk("rf2 free", 32'h1, rf2_ctl.run);
        wr(`OPDC_ADDR_RF_POWER, 8'h11);
        settle();
        chk("rf1 pd", 32'h0, rf1_ctl.run);
        chk("rf2 on", 32'h1, rf2_ctl.run);
        wr(`OPDC_ADDR_RF_POWER, 8'h12);
        settle();
        chk("rf1 on", 32'h1, rf1_ctl.run);
        chk("rf2 pd", 32'h0, rf2_ctl.run);
        wr(`OPDC_ADDR_RF_POWER, 8'h00);
        settle();
        chk("rf1 held", 32'h0, rf1_ctl.run);
        // a feedback pulse while the clock enable is low must be missed
        @(posedge clock);
        clk_en        <= 1'b0;
        fb_div_active <= 1'b1;
        @(posedge clock);
        fb_div_active <= 1'b0;
        @(posedge clock);
        clk_en        <= 1'b1;
        settle();
        chk("rf1 frozen", 32'h0, rf1_ctl.run);
        @(posedge clock);
        fb_div_active <= 1'b1;
        @(posedge clock);
        fb_div_active <= 1'b0;
        settle();
        chk("rf1 seen", 32'h1, rf1_ctl.run);
        chk("rf2 seen", 32'h1, rf2_ctl.run);
        // released hold-off shows as status bit 8 of the power register
        rd_chk("power reg", `OPDC_ADDR_RF_POWER, 32'h100);
        $display("test power done");
        end_sim();
    end
endmodule // output_pll_divider_control_bench
